// ### pkg/imuspi_map.svh
// timing and code constants for the inertial sensor spi timing block
// Overview of operation
// - period setting up to 09h is normal mode
// - power-on data after 220/290 ms
// - reset recovery data after 100/170 ms
// - sleep wake data after 4/15 ms
// - flash test lasts 17/90 ms
// - sample rate 3.21 to 819.2 sps
// - data ready 600 us after sync
// - temperature zero at 25 C, 0.14 C/code
// - aux dac 12-bit, accurate 101..4095
// - shift out falling, sample rising edges
// - each sample while running loads results, pulses ready
`ifndef IMUSPI_MAP_SVH
`define IMUSPI_MAP_SVH
// ****************************************
// mode thresholds
// ****************************************
`define IMUSPI_NORMAL_MAX 8'h09
// ****************************************
// times in their own units
// ****************************************
`define IMUSPI_CLK_MHZ 100
`define IMUSPI_PWRUP_NORM_MS 220
`define IMUSPI_PWRUP_LP_MS 290
`define IMUSPI_RESET_NORM_MS 100
`define IMUSPI_RESET_LP_MS 170
`define IMUSPI_SLEEP_NORM_MS 4
`define IMUSPI_SLEEP_LP_MS 15
`define IMUSPI_FLASH_NORM_MS 17
`define IMUSPI_FLASH_LP_MS 90
`define IMUSPI_SYNC_DR_US 600
`define IMUSPI_WAKE_US 20
// base sample tick: 819.2 sps is 1220703 ns, shortest period
`define IMUSPI_BASE_NS 1220703
// ****************************************
// derived cycle counts
// ****************************************
`define IMUSPI_MS_CYC(ms) ((ms) * 1000 * `IMUSPI_CLK_MHZ)
`define IMUSPI_US_CYC(us) ((us) * `IMUSPI_CLK_MHZ)
`define IMUSPI_BASE_CYC (`IMUSPI_BASE_NS / 10)
// ****************************************
// codes
// ****************************************
`define IMUSPI_TEMP_ZERO 16'h0000
`define IMUSPI_DAC_MIN 12'h065
`define IMUSPI_DAC_MAX 12'hFFF
`define IMUSPI_WORD_BITS 16
`define IMUSPI_CNT_W 32
`endif

// ### pkg/imuspi_pkg.sv
// types for the inertial sensor spi timing block
package imuspi_pkg;
  // device activity states
  typedef enum logic [2:0] {
    IMUSPI_ST_BOOT = 3'b000,
    IMUSPI_ST_RUN = 3'b001,
    IMUSPI_ST_SLEEP = 3'b010,
    IMUSPI_ST_WAKE = 3'b011,
    IMUSPI_ST_FLASH = 3'b100
  } imuspi_state_t;
endpackage

// ### src/imuspi_link.sv
// spi slave shift logic on the serial clock domain
`timescale 1ns/1ps
`include "imuspi_map.svh"
module imuspi_link (
  sclk,
  reset_n,
  cs_n,
  din,
  tx_word,
  dout,
  rx_word,
  rx_toggle
);
  input wire logic sclk; // idle high serial clock
  input wire logic reset_n; // system reset, only for the word toggle
  input wire logic cs_n; // select, also frames the link
  input wire logic din; // master data in
  input wire logic [15:0] tx_word; // word from system side, steady between ready pulses
  output logic dout; // data to master
  output logic [15:0] rx_word; // last received word
  output logic rx_toggle; // flips once per whole word
  logic [15:0] sh_reg, sh_next; // receive shift
  logic [15:0] tx_reg, tx_next; // transmit shift
  logic [3:0] cnt_reg, cnt_next; // bit count in word
  logic [15:0] rxw_reg, rxw_next; // captured word
  logic tog_reg, tog_next; // word event toggle
  logic out_reg, out_next; // output bit, falling edge
  // ****************************************
  // next values for both serial edges
  // ****************************************
  always_comb begin
    sh_next = {sh_reg[14:0], din};
    cnt_next = cnt_reg + 4'h1;
    rxw_next = rxw_reg;
    tog_next = tog_reg;
    tx_next = {tx_reg[14:0], 1'b0};
    if (cnt_reg == 4'h0) begin
      // msb already left on the first fall, keep the rest
      tx_next = {tx_word[14:0], 1'b0};
    end
    if (cnt_reg == 4'hF) begin
      // word complete, hand over by toggle
      rxw_next = {sh_reg[14:0], din};
      tog_next = ~tog_reg;
    end
    // limitation: a word reload between first fall and first rise tears it,
    // the master reads right after the ready pulse, far from the next one
    out_next = (cnt_reg == 4'h0) ? tx_word[15] : tx_reg[15];
  end
  // clock stops outside frames, so select restarts the word
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_reg <= 4'h0;
      sh_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
    end
  end
  always_ff @(posedge sclk) begin
    rxw_reg <= rxw_next;
  end
  // serial clock stands still while the system is held in reset,
  // so releasing this reset cannot meet a clock edge
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      tog_reg <= 1'b0;
    end else begin
      tog_reg <= tog_next;
    end
  end
  // transmit register loads on the first rise of each word
  always_ff @(posedge sclk) begin
    tx_reg <= tx_next;
  end
  // ****************************************
  // falling edge: shift output
  // ****************************************
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) out_reg <= 1'b0;
    else out_reg <= out_next;
  end
  assign dout = out_reg;
  assign rx_word = rxw_reg;
  assign rx_toggle = tog_reg;
endmodule

// ### src/imuspi_top.sv
// timing and mode core of the inertial sensor spi port
`timescale 1ns/1ps
`include "imuspi_map.svh"
module imuspi_top #(
  parameter int unsigned PWRUP_NORM_CYC = `IMUSPI_MS_CYC(`IMUSPI_PWRUP_NORM_MS),
  parameter int unsigned PWRUP_LP_CYC = `IMUSPI_MS_CYC(`IMUSPI_PWRUP_LP_MS),
  parameter int unsigned RESET_NORM_CYC = `IMUSPI_MS_CYC(`IMUSPI_RESET_NORM_MS),
  parameter int unsigned RESET_LP_CYC = `IMUSPI_MS_CYC(`IMUSPI_RESET_LP_MS),
  parameter int unsigned SLEEP_NORM_CYC = `IMUSPI_MS_CYC(`IMUSPI_SLEEP_NORM_MS),
  parameter int unsigned SLEEP_LP_CYC = `IMUSPI_MS_CYC(`IMUSPI_SLEEP_LP_MS),
  parameter int unsigned FLASH_NORM_CYC = `IMUSPI_MS_CYC(`IMUSPI_FLASH_NORM_MS),
  parameter int unsigned FLASH_LP_CYC = `IMUSPI_MS_CYC(`IMUSPI_FLASH_LP_MS),
  parameter int unsigned SYNC_DR_CYC = `IMUSPI_US_CYC(`IMUSPI_SYNC_DR_US),
  parameter int unsigned WAKE_CYC = `IMUSPI_US_CYC(`IMUSPI_WAKE_US),
  parameter int unsigned BASE_CYC = `IMUSPI_BASE_CYC
) (
  sys_clk,
  reset_n,
  sample_period_setting,
  sync_enable,
  sync_clock_input,
  sleep_request,
  flash_test_request,
  warm_start,
  sensor_word,
  temperature_word,
  aux_dac_code,
  sclk,
  cs_n,
  din,
  dout,
  data_ready_pin,
  data_valid,
  low_power_mode,
  aux_dac_out,
  aux_dac_in_range,
  host_word,
  host_word_strobe
);
  input wire logic sys_clk; // system clock 100 MHz
  input wire logic reset_n; // synchronous, active low
  input wire logic [7:0] sample_period_setting; // sample period multiplier
  input wire logic sync_enable; // use external sample clock
  input wire logic sync_clock_input; // external sync pin
  input wire logic sleep_request; // enter sleep
  input wire logic flash_test_request; // start flash test pulse
  input wire logic warm_start; // reset is a user reset, not power-up
  input wire logic [15:0] sensor_word; // fresh result from sensors
  input wire logic [15:0] temperature_word; // offset from 25 C in 0.14 C codes
  input wire logic [11:0] aux_dac_code; // aux dac code
  input wire logic sclk; // serial clock pin
  input wire logic cs_n; // chip select pin
  input wire logic din; // serial data in pin
  output logic dout; // serial data out pin
  output logic data_ready_pin; // one-cycle ready pulse
  output logic data_valid; // data currently valid
  output logic low_power_mode; // mode indication
  output logic [11:0] aux_dac_out; // registered dac code
  output logic aux_dac_in_range; // code inside accurate span
  output logic [15:0] host_word; // last word from master
  output logic host_word_strobe; // one-cycle on new word
  // ****************************************
  // declarations
  // ****************************************
  imuspi_pkg::imuspi_state_t st_reg, st_next; // activity state
  logic [31:0] tmr_reg, tmr_next; // recovery timer
  logic [31:0] smp_reg, smp_next; // sample interval timer
  logic [7:0] mul_reg, mul_next; // period multiplier count
  logic [31:0] sdr_reg, sdr_next; // sync to ready timer
  logic sdr_run_reg, sdr_run_next; // sync delay pending
  logic [15:0] out_reg, out_next; // output register to link
  logic rdy_reg, rdy_next; // ready pulse
  logic boot_kind_reg, boot_kind_next; // 0 power-up, 1 warm reset
  logic [11:0] dac_reg, dac_next; // dac code holder
  logic [31:0] wk_reg, wk_next; // select low width
  logic [2:0] sync_ff; // sync pin synchroniser, edge stage
  logic [1:0] cs_ff; // select synchroniser
  logic [2:0] tog_ff; // word toggle synchroniser
  logic lp; // low-power mode
  logic tick; // sample tick
  logic sync_rise; // synchronised sync edge
  logic [15:0] rx_word; // word from link, stable after toggle
  logic rx_toggle; // word event from link
  logic [15:0] hw_reg, hw_next; // captured host word
  logic hws_reg, hws_next; // capture strobe
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] pick(input logic lpm, input int unsigned n,
                                        input int unsigned l);
    pick = lpm ? 32'(l) : 32'(n);
  endfunction
  assign lp = (sample_period_setting > `IMUSPI_NORMAL_MAX);
  // ****************************************
  // synchronisers for pins
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sync_ff <= 3'h0;
      cs_ff <= 2'h3;
      tog_ff <= 3'h0;
    end else begin
      sync_ff <= {sync_ff[1:0], sync_clock_input};
      cs_ff <= {cs_ff[0], cs_n};
      tog_ff <= {tog_ff[1:0], rx_toggle};
    end
  end
  assign sync_rise = sync_ff[1] & ~sync_ff[2];
  // ****************************************
  // state machine and timers
  // ****************************************
  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_reg;
    wk_next = cs_ff[1] ? 32'h0 : wk_reg + 32'h1;
    boot_kind_next = boot_kind_reg;
    case (st_reg)
      imuspi_pkg::IMUSPI_ST_BOOT: begin
        // first data after power-up or reset recovery
        if (tmr_reg == 32'h0) begin
          // kind of start is latched on the first cycle after release
          boot_kind_next = warm_start;
        end
        tmr_next = tmr_reg + 32'h1;
        if (tmr_reg + 32'h1 >= (boot_kind_reg ? pick(lp, RESET_NORM_CYC, RESET_LP_CYC)
            : pick(lp, PWRUP_NORM_CYC, PWRUP_LP_CYC))) begin
          st_next = imuspi_pkg::IMUSPI_ST_RUN;
          tmr_next = 32'h0;
        end
      end
      imuspi_pkg::IMUSPI_ST_RUN: begin
        if (flash_test_request) begin
          st_next = imuspi_pkg::IMUSPI_ST_FLASH;
        end else if (sleep_request) begin
          st_next = imuspi_pkg::IMUSPI_ST_SLEEP;
        end
      end
      imuspi_pkg::IMUSPI_ST_SLEEP: begin
        // wake needs select held low long enough
        if (wk_reg >= 32'(WAKE_CYC) && !sleep_request) begin
          st_next = imuspi_pkg::IMUSPI_ST_WAKE;
          tmr_next = 32'h0;
        end
      end
      imuspi_pkg::IMUSPI_ST_WAKE: begin
        tmr_next = tmr_reg + 32'h1;
        if (tmr_reg + 32'h1 >= pick(lp, SLEEP_NORM_CYC, SLEEP_LP_CYC)) begin
          st_next = imuspi_pkg::IMUSPI_ST_RUN;
          tmr_next = 32'h0;
        end
      end
      imuspi_pkg::IMUSPI_ST_FLASH: begin
        tmr_next = tmr_reg + 32'h1;
        if (tmr_reg + 32'h1 >= pick(lp, FLASH_NORM_CYC, FLASH_LP_CYC)) begin
          st_next = imuspi_pkg::IMUSPI_ST_RUN;
          tmr_next = 32'h0;
        end
      end
      default: begin
        st_next = imuspi_pkg::IMUSPI_ST_BOOT;
        tmr_next = 32'h0;
      end
    endcase
  end
  // boot kind caught at release, never under reset from a port
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_reg <= imuspi_pkg::IMUSPI_ST_BOOT;
      tmr_reg <= 32'h0;
      wk_reg <= 32'h0;
      boot_kind_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      wk_reg <= wk_next;
      boot_kind_reg <= boot_kind_next;
    end
  end
  // ****************************************
  // sample clock, sync path and output load
  // ****************************************
  // internal tick: period is setting times base tick; setting 0 held as 1
  always_comb begin
    smp_next = smp_reg + 32'h1;
    mul_next = mul_reg;
    tick = 1'b0;
    if (smp_reg + 32'h1 >= 32'(BASE_CYC)) begin
      smp_next = 32'h0;
      mul_next = mul_reg + 8'h1;
      if (mul_reg + 8'h1 >= sample_period_setting) begin
        mul_next = 8'h0;
        tick = ~sync_enable;
      end
    end
    // external sync: ready fixed delay after pulse
    sdr_next = sdr_reg;
    sdr_run_next = sdr_run_reg;
    if (sync_enable && sync_rise) begin
      sdr_run_next = 1'b1;
      sdr_next = 32'h0;
    end else if (sdr_run_reg) begin
      sdr_next = sdr_reg + 32'h1;
      if (sdr_reg + 32'h1 >= 32'(SYNC_DR_CYC)) begin
        sdr_run_next = 1'b0;
        tick = 1'b1;
      end
    end
    out_next = out_reg;
    rdy_next = 1'b0;
    if (tick && st_reg == imuspi_pkg::IMUSPI_ST_RUN) begin
      out_next = sensor_word ^ temperature_word ^ `IMUSPI_TEMP_ZERO;
      rdy_next = 1'b1;
    end
    dac_next = aux_dac_code;
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      smp_reg <= 32'h0;
      mul_reg <= 8'h0;
      sdr_reg <= 32'h0;
      sdr_run_reg <= 1'b0;
      out_reg <= 16'h0000;
      rdy_reg <= 1'b0;
      dac_reg <= 12'h000;
    end else begin
      smp_reg <= smp_next;
      mul_reg <= mul_next;
      sdr_reg <= sdr_next;
      sdr_run_reg <= sdr_run_next;
      out_reg <= out_next;
      rdy_reg <= rdy_next;
      dac_reg <= dac_next;
    end
  end
  // ****************************************
  // link on the serial clock
  // ****************************************
  imuspi_link u_link (
    .sclk(sclk),
    .reset_n(reset_n),
    .cs_n(cs_n),
    .din(din),
    .tx_word(out_reg),
    .dout(dout),
    .rx_word(rx_word),
    .rx_toggle(rx_toggle)
  );
  // word is stable long before the toggle arrives here
  always_comb begin
    hws_next = tog_ff[1] ^ tog_ff[2];
    hw_next = hw_reg;
    if (hws_next) begin
      hw_next = rx_word;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      hw_reg <= 16'h0000;
      hws_reg <= 1'b0;
    end else begin
      hw_reg <= hw_next;
      hws_reg <= hws_next;
    end
  end
  assign data_ready_pin = rdy_reg;
  assign data_valid = (st_reg == imuspi_pkg::IMUSPI_ST_RUN);
  assign low_power_mode = lp;
  assign aux_dac_out = dac_reg;
  assign aux_dac_in_range = (dac_reg >= `IMUSPI_DAC_MIN);
  assign host_word = hw_reg;
  assign host_word_strobe = hws_reg;
endmodule

// ### bench/imuspi_top_asserts.sv
// port assertions for the spi timing core
`timescale 1ns/1ps
module imuspi_top_asserts #(
  parameter int unsigned SYNC_DR_CYC = 60,
  parameter int unsigned FLASH_NORM_CYC = 170
) (
  sys_clk,
  reset_n,
  sample_period_setting,
  sync_enable,
  sync_clock_input,
  flash_test_request,
  aux_dac_code,
  cs_n,
  dout,
  data_ready_pin,
  data_valid,
  low_power_mode,
  aux_dac_out,
  aux_dac_in_range,
  host_word,
  host_word_strobe
);
  input wire logic sys_clk;
  input wire logic reset_n;
  input wire logic [7:0] sample_period_setting;
  input wire logic sync_enable;
  input wire logic sync_clock_input;
  input wire logic flash_test_request;
  input wire logic [11:0] aux_dac_code;
  input wire logic cs_n;
  input wire logic dout;
  input wire logic data_ready_pin;
  input wire logic data_valid;
  input wire logic low_power_mode;
  input wire logic [11:0] aux_dac_out;
  input wire logic aux_dac_in_range;
  input wire logic [15:0] host_word;
  input wire logic host_word_strobe;
  // ****************************************
  // windows, slack covers the sync stages
  // ****************************************
  localparam int SD_LO = int'(SYNC_DR_CYC);
  localparam int SD_HI = int'(SYNC_DR_CYC) + 6;
  localparam int FL_LO = int'(FLASH_NORM_CYC) - 5;
  localparam int FL_HI = int'(FLASH_NORM_CYC) + 4;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // sync edge seen while running
  sequence sync_rise;
    $rose(sync_clock_input) && sync_enable && data_valid;
  endsequence
  // flash test accepted in normal mode
  sequence flash_start;
    data_valid && flash_test_request && !low_power_mode ##1 !data_valid;
  endsequence
  lp_mode_a: assert property (low_power_mode == (sample_period_setting > 8'h09))
    else $error("mode flag wrong for period setting");
  ready_pulse_a: assert property (data_ready_pin |=> !data_ready_pin)
    else $error("ready pulse longer than one cycle");
  ready_valid_a: assert property (data_ready_pin |-> $past(data_valid))
    else $error("ready pulse while not running");
  sync_ready_a: assert property (sync_rise |-> ##[SD_LO:SD_HI] data_ready_pin)
    else $error("no ready after sync edge");
  flash_time_a: assert property (flash_start |-> ##[FL_LO:FL_HI] $rose(data_valid))
    else $error("flash test time wrong");
  dac_reg_a: assert property (1'b1 |=> aux_dac_out == $past(aux_dac_code))
    else $error("dac output not following code");
  dac_range_a: assert property (aux_dac_in_range == (aux_dac_out >= 12'h065))
    else $error("dac range flag wrong");
  word_stable_a: assert property (!$stable(host_word) |-> host_word_strobe)
    else $error("host word changed without strobe");
  strobe_pulse_a: assert property (host_word_strobe |=> !host_word_strobe)
    else $error("strobe longer than one cycle");
  dout_idle_a: assert property (cs_n && $past(cs_n) |-> !dout)
    else $error("dout driven while deselected");
endmodule
bind imuspi_top imuspi_top_asserts #(.SYNC_DR_CYC(SYNC_DR_CYC),
  .FLASH_NORM_CYC(FLASH_NORM_CYC)) i_asserts (.sys_clk(sys_clk), .reset_n(reset_n),
  .sample_period_setting(sample_period_setting), .sync_enable(sync_enable),
  .sync_clock_input(sync_clock_input), .flash_test_request(flash_test_request),
  .aux_dac_code(aux_dac_code), .cs_n(cs_n), .dout(dout), .data_ready_pin(data_ready_pin),
  .data_valid(data_valid), .low_power_mode(low_power_mode), .aux_dac_out(aux_dac_out),
  .aux_dac_in_range(aux_dac_in_range), .host_word(host_word),
  .host_word_strobe(host_word_strobe));

// ### bench/imuspi_master.sv
// spi master model on the serial side
`timescale 1ns/1ps
module imuspi_master (
  cs_n,
  sclk,
  din,
  dout
);
  output logic cs_n; // select, idle high
  output logic sclk; // stands high outside frames
  output logic din; // data to device
  input wire logic dout; // data from device
  initial begin
    cs_n = 1'b0;
    sclk = 1'b1;
    din = 1'b1;
    // a clean deselect edge clears the link's bit count
    #1;
    cs_n = 1'b1;
  end
  // one word, mode 3, msb first, 12 ns serial period
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n = 1'b0;
    #60;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];
      // serial period scaled down like every other time here
      #6;
      sclk = 1'b1;
      rx[i] = dout;
      #6;
    end
    #60;
    cs_n = 1'b1;
    din = ~din; // released line shows no stale bit
    #9000;
  endtask
  // select held low for a given time
  task automatic hold(input int ns);
    cs_n = 1'b0;
    #(ns);
    cs_n = 1'b1;
  endtask
endmodule

// ### bench/testbench.sv
// self-checking bench for the spi timing core
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // shortened times in 10 ns cycles
  // ****************************************
  localparam int PN = 220, PL = 290, RN = 100, RL = 170, SN = 40, SL = 150;
  localparam int FN = 170, FL = 900, SD = 60, WK = 20, BC = 20, LIMIT = 30000;
  logic sys_clk = 1'b0, reset_n = 1'b0, sync_enable = 1'b0, sync_clock_input = 1'b0;
  logic sleep_request = 1'b0, flash_test_request = 1'b0, warm_start = 1'b0;
  logic [7:0] sample_period_setting = 8'h01;
  logic [15:0] sensor_word = 16'hA5C3, temperature_word = 16'h0000, host_word, rx;
  logic [11:0] aux_dac_code = 12'h000, aux_dac_out;
  logic sclk, cs_n, din, dout, data_ready_pin, data_valid, low_power_mode;
  logic aux_dac_in_range, host_word_strobe;
  int fail_count = 0, total_checks = 0, cycles = 0, n;
  always #5 sys_clk = ~sys_clk;
  imuspi_top #(.PWRUP_NORM_CYC(PN), .PWRUP_LP_CYC(PL), .RESET_NORM_CYC(RN),
    .RESET_LP_CYC(RL), .SLEEP_NORM_CYC(SN), .SLEEP_LP_CYC(SL), .FLASH_NORM_CYC(FN),
    .FLASH_LP_CYC(FL), .SYNC_DR_CYC(SD), .WAKE_CYC(WK), .BASE_CYC(BC)) i_imuspi_top (
    .sys_clk(sys_clk), .reset_n(reset_n), .sample_period_setting(sample_period_setting),
    .sync_enable(sync_enable), .sync_clock_input(sync_clock_input),
    .sleep_request(sleep_request), .flash_test_request(flash_test_request),
    .warm_start(warm_start), .sensor_word(sensor_word),
    .temperature_word(temperature_word), .aux_dac_code(aux_dac_code), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .data_ready_pin(data_ready_pin),
    .data_valid(data_valid), .low_power_mode(low_power_mode), .aux_dac_out(aux_dac_out),
    .aux_dac_in_range(aux_dac_in_range), .host_word(host_word),
    .host_word_strobe(host_word_strobe));
  imuspi_master i_imuspi_master (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  // cycles until running again, bounded
  task automatic wait_valid();
    n = 0;
    while (data_valid !== 1'b1 && n < 3000) begin
      tick();
      n++;
    end
  endtask
  task automatic wait_ready();
    n = 0;
    tick();
    while (data_ready_pin !== 1'b1 && n < 3000) begin
      tick();
      n++;
    end
  endtask
  // count within a few cycles of the figure
  task automatic near(input int exp);
    check(n + 4 >= exp && n <= exp + 4, 1'b1);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_boot();
    logic [7:0] st [4] = '{8'h01, 8'h0A, 8'h09, 8'h0A};
    int ex [4] = '{PN, PL, RN, RL};
    for (int i = 0; i < 4; i++) begin
      reset_n = 1'b0;
      warm_start = i[1];
      sample_period_setting = st[i];
      repeat (10) tick();
      check(low_power_mode, i[0]);
      reset_n = 1'b1;
      wait_valid();
      near(ex[i]);
    end
  endtask
  task automatic t_rate();
    for (int s = 2; s > 0; s--) begin
      sample_period_setting = s[7:0];
      repeat (3) wait_ready();
      check(n + 1, s * BC);
    end
  endtask
  task automatic t_spi();
    wait_ready();
    fork
      i_imuspi_master.xfer(16'h3C96, rx);
      begin
        wait_ready();
        n = 0;
        while (host_word_strobe !== 1'b1 && n < 3000) begin
          tick();
          n++;
        end
        check(host_word, 16'h3C96);
      end
    join
    check(rx, 16'hA5C3);
  endtask
  task automatic t_sleep();
    for (int i = 0; i < 2; i++) begin
      sample_period_setting = i ? 8'h0A : 8'h01;
      sleep_request = 1'b1;
      repeat (3) tick();
      check(data_valid, 1'b0);
      sleep_request = 1'b0;
      i_imuspi_master.hold(100);
      repeat (SL + 30) tick();
      check(data_valid, 1'b0);
      i_imuspi_master.hold(300);
      wait_valid();
      check(n <= (i ? SL : SN) + 4 && n + WK + 8 >= (i ? SL : SN), 1'b1);
    end
  endtask
  task automatic t_flash();
    for (int i = 0; i < 2; i++) begin
      sample_period_setting = i ? 8'h0A : 8'h01;
      tick();
      flash_test_request = 1'b1;
      tick();
      flash_test_request = 1'b0;
      check(data_valid, 1'b0);
      wait_valid();
      near(i ? FL : FN);
    end
  endtask
  task automatic t_sync();
    sample_period_setting = 8'h01;
    sync_enable = 1'b1;
    repeat (5) tick();
    sync_clock_input = 1'b1;
    repeat (5) tick();
    sync_clock_input = 1'b0;
    wait_ready();
    check(n + 6 >= SD && n + 6 <= SD + 6, 1'b1);
    sync_enable = 1'b0;
  endtask
  task automatic t_dac();
    logic [11:0] cd [4] = '{12'h064, 12'h065, 12'hFFF, 12'h000};
    foreach (cd[i]) begin
      aux_dac_code = cd[i];
      repeat (2) tick();
      check(aux_dac_out, cd[i]);
      check(aux_dac_in_range, cd[i] >= 12'h065);
    end
  endtask
  // ****************************************
  // sequence, watchdog and verdict
  // ****************************************
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    t_boot();
    t_rate();
    t_spi();
    t_sleep();
    t_flash();
    t_sync();
    t_dac();
    print_verdict();
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      print_verdict();
    end
  end
endmodule
